// ---- logic/imr_core.sv ----
/*
 * Execution of the indirect accumulator store, the idle instruction, the
 * software reset and the interrupt return. Assumes a decoder presents one
 * instruction per start pulse and waits for done before the next.
 * The soft reset pulse must be routed back to resetn_i by the system.
 */
`timescale 1ns/10ps

// Operation
// - Store accumulator at address in selected pointer
// - Update code selects pre/post increment/decrement
// - Relative form adds signed offset, pointer unchanged
// - Pointers sixteen bits, wrap without saturation
// - Store and pointer updates leave flags alone
// - Software reset resets device, clears reset flag; here the reset fed back on resetn_i loads the flag with 1 again
// - Interrupt return pops stack into program counter
// - Interrupt return sets global interrupt enable
// - Interrupt return one word, two cycles, flags kept
module imr_core (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire imr_pkg::imr_op_t op_i,
    input wire logic ptr_sel_i,
    input wire logic [1:0] pointer_update_code_i,
    input wire logic [5:0] offset_i,
    input wire logic [7:0] accumulator_i,
    input wire logic call_i,
    input wire logic [12:0] call_target_i,
    input wire logic int_disable_i,
    input wire logic reset_flag_set_i,
    output logic done_o,
    output logic mem_we_o,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic [15:0] file_select_pointer0_o,
    output logic [15:0] file_select_pointer1_o,
    output logic [12:0] pc_o,
    output logic [7:0] interrupt_control_register_o,
    output logic global_interrupt_enable_o,
    output logic reset_instruction_flag_o,
    output logic soft_reset_o,
    output logic [3:0] stack_depth_o
);

    // Return sequencer states
    typedef enum logic [1:0] {
        IMR_IDLE,
        IMR_RET2
    } imr_state_t;

    imr_stack_if st ();

    imr_stack u_stack (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .st(st)
    );

    // Pointer step with natural 16-bit wrap
    function automatic logic [15:0] step(input logic [15:0] p, input logic down);
        step = down ? p - 16'h0001 : p + 16'h0001;
    endfunction

    // Architectural registers and registered port values
    logic [15:0] fsr0;
    logic [15:0] fsr1;
    logic [12:0] pc;
    logic [7:0] interrupt_control_register;
    logic ri;
    logic soft_rst;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
    imr_state_t state;
    imr_state_t next_state;

    ////////////////////////////////////////////////////////////////////////
    // Decode and address arithmetic. A start in the second return cycle is
    // refused outright and no port shows it, so the decoder waits for done.
    wire logic accept = start_i && (state == IMR_IDLE);
    wire logic is_ind = accept && (op_i == imr_pkg::IMR_OP_STORE_IND);
    wire logic is_rel = accept && (op_i == imr_pkg::IMR_OP_STORE_REL);
    wire logic is_idle = accept && (op_i == imr_pkg::IMR_OP_IDLE);
    wire logic is_rst = accept && (op_i == imr_pkg::IMR_OP_SOFT_RESET);
    wire logic is_ret = accept && (op_i == imr_pkg::IMR_OP_INT_RETURN);
    wire logic [15:0] sel_ptr = ptr_sel_i ? fsr1 : fsr0;
    wire logic down = pointer_update_code_i[0];
    wire logic pre = !pointer_update_code_i[1];
    wire logic [15:0] stepped = step(sel_ptr, down);
    wire logic [15:0] ind_addr = pre ? stepped : sel_ptr;
    wire logic [15:0] rel_addr = sel_ptr + {{10{offset_i[5]}}, offset_i};
    wire logic upd0 = is_ind && !ptr_sel_i;
    wire logic upd1 = is_ind && ptr_sel_i;
    wire logic advance = is_ind || is_rel || is_idle;

    // Stack control: return pops, call pushes when idle
    // A call that meets a return accept is dropped; the return wins
    assign st.pop = is_ret;
    assign st.push = call_i && (state == IMR_IDLE) && !is_ret;
    assign st.push_data = pc + 13'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Return sequencing: two cycles
    always_comb begin
        next_state = state;
        case (state)
            IMR_IDLE: begin
                if (is_ret) begin
                    next_state = IMR_RET2;
                end
            end
            IMR_RET2: next_state = IMR_IDLE;
            default: next_state = IMR_IDLE;
        endcase
    end

    // Done: take cycle for single-cycle kinds, second cycle for a return
    assign done_o = is_idle || is_ind || is_rel || is_rst || (state == IMR_RET2);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= IMR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Pointer 0; the step touches no status flag, even on wrap
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fsr0 <= imr_pkg::IMR_PTR_RST;
        end else if (upd0) begin
            fsr0 <= stepped;
        end
    end

    // Pointer 1; same step and wrap as pointer 0
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fsr1 <= imr_pkg::IMR_PTR_RST;
        end else if (upd1) begin
            fsr1 <= stepped;
        end
    end

    // Program counter
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc <= imr_pkg::IMR_PC_RST;
        end else if (is_ret) begin
            pc <= st.top_data;
        end else if (st.push) begin
            pc <= call_target_i;
        end else if (advance) begin
            pc <= pc + 13'h0001;
        end
    end

    // Interrupt control: return sets enable, set wins over clear
    // The disable input stands in for software clearing the enable bit
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            interrupt_control_register <= imr_pkg::IMR_INTERRUPT_CONTROL_REGISTER_RST;
        end else if (is_ret) begin
            interrupt_control_register[imr_pkg::IMR_GIE_BIT] <= 1'b1;
        end else if (int_disable_i) begin
            interrupt_control_register[imr_pkg::IMR_GIE_BIT] <= 1'b0;
        end
    end

    // Data write port, registered one cycle after the take
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            we <= 1'b0;
            addr <= imr_pkg::IMR_PTR_RST;
            wdata <= 8'h00;
        end else begin
            we <= is_ind || is_rel;
            addr <= is_rel ? rel_addr : ind_addr;
            wdata <= accumulator_i;
        end
    end

    // Software reset request, one cycle; the system feeds it to reset
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= is_rst;
        end
    end

    // Reset cause flag: cleared by software reset, set by software
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ri <= 1'b1;
        end else if (is_rst) begin
            ri <= 1'b0;
        end else if (reset_flag_set_i) begin
            ri <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port drivers, all straight from registers
    assign mem_we_o = we;
    assign mem_addr_o = addr;
    assign mem_wdata_o = wdata;
    assign file_select_pointer0_o = fsr0;
    assign file_select_pointer1_o = fsr1;
    assign pc_o = pc;
    assign interrupt_control_register_o = interrupt_control_register;
    assign global_interrupt_enable_o = interrupt_control_register[imr_pkg::IMR_GIE_BIT];
    assign reset_instruction_flag_o = ri;
    assign soft_reset_o = soft_rst;
    assign stack_depth_o = st.depth;

endmodule // imr_core

// ---- logic/imr_pkg.sv ----
/*
 * Package for the indirect store, idle, software reset and interrupt return
 * execution block. Assumes a 20 MHz instruction clock and 16-bit data addresses.
 */
package imr_pkg;

    // Instruction kinds presented by the decoder
    typedef enum logic [2:0] {
        IMR_OP_NONE,
        IMR_OP_IDLE,
        IMR_OP_STORE_IND,
        IMR_OP_STORE_REL,
        IMR_OP_SOFT_RESET,
        IMR_OP_INT_RETURN
    } imr_op_t;

    // Pointer update codes
    localparam logic [1:0] IMR_MM_PREINC = 2'h0;
    localparam logic [1:0] IMR_MM_PREDEC = 2'h1;
    localparam logic [1:0] IMR_MM_POSTINC = 2'h2;
    localparam logic [1:0] IMR_MM_POSTDEC = 2'h3;

    // Widths and positions
    localparam int IMR_PTR_W = 16;
    localparam int IMR_PC_W = 13;
    localparam int IMR_STACK_DEPTH = 16;
    localparam int IMR_SP_W = 4;
    localparam int IMR_GIE_BIT = 7;

    // Values after reset
    localparam logic [15:0] IMR_PTR_RST = 16'h0000;
    localparam logic [12:0] IMR_PC_RST = 13'h0000;
    localparam logic [3:0] IMR_SP_RST = 4'h0;
    localparam logic [7:0] IMR_INTERRUPT_CONTROL_REGISTER_RST = 8'h00;

    // Cycle counts
    localparam logic [1:0] IMR_RETURN_CYCLES = 2'h2;
    localparam logic [1:0] IMR_IDLE_CYCLES = 2'h1;

endpackage

// ---- logic/imr_stack_if.sv ----
/*
 * Interface between the execution block and its return stack memory.
 * Assumes a single clock shared by both ends.
 */
`timescale 1ns/10ps
interface imr_stack_if;
    logic push;
    logic pop;
    logic [12:0] push_data;
    logic [12:0] top_data;
    logic [3:0] depth;

    modport core (output push, output pop, output push_data, input top_data, input depth);
    modport mem (input push, input pop, input push_data, output top_data, output depth);
endinterface

// ---- logic/imr_stack.sv ----
/*
 * Hardware return stack: circular store of program counter entries, top entry
 * held in a register. Assumes push and pop never coincide.
 */
`timescale 1ns/10ps
module imr_stack (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    imr_stack_if.mem st
);

    logic [12:0] mem [imr_pkg::IMR_STACK_DEPTH];
    logic [3:0] sp;
    logic [12:0] top;

    ////////////////////////////////////////////////////////////////////////
    // Pointer and top register
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sp <= imr_pkg::IMR_SP_RST;
            top <= imr_pkg::IMR_PC_RST;
        end else if (st.push) begin
            sp <= sp + 4'h1;
            top <= st.push_data;
        end else if (st.pop) begin
            sp <= sp - 4'h1;
            top <= mem[4'(sp - 4'h2)]; // Wraps on underflow
        end
    end

    // Storage array
    always_ff @(posedge sys_clk_i) begin
        if (st.push) begin
            mem[sp] <= st.push_data;
        end
    end

    assign st.top_data = top;
    assign st.depth = sp;

endmodule // imr_stack

// ---- sim/imr_core_properties.sv ----
/* Checks on the execution block ports.
   Assumes one clock and the decoder handshake of imr_core. */
`timescale 1ns/10ps
module imr_props (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire imr_pkg::imr_op_t op_i,
    input wire logic ptr_sel_i,
    input wire logic [1:0] pointer_update_code_i,
    input wire logic [7:0] accumulator_i,
    input wire logic done_o,
    input wire logic mem_we_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic [15:0] file_select_pointer0_o,
    input wire logic [12:0] pc_o,
    input wire logic global_interrupt_enable_o,
    input wire logic reset_instruction_flag_o,
    input wire logic soft_reset_o,
    input wire logic [3:0] stack_depth_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // Accepted instruction kinds
    wire st_w = start_i && op_i == imr_pkg::IMR_OP_STORE_IND;
    wire rel_w = start_i && op_i == imr_pkg::IMR_OP_STORE_REL && !ptr_sel_i;
    wire idle_w = start_i && op_i == imr_pkg::IMR_OP_IDLE;
    wire ret_w = start_i && op_i == imr_pkg::IMR_OP_INT_RETURN;
    wire sr_w = start_i && op_i == imr_pkg::IMR_OP_SOFT_RESET;
    wire p0_w = st_w && !ptr_sel_i;
    ////////////////////////////////////////
    store_write_a: assert property (st_w |=> mem_we_o && mem_wdata_o == $past(accumulator_i))
        else $error("store write wrong");
    preinc_addr_a: assert property (p0_w && pointer_update_code_i == imr_pkg::IMR_MM_PREINC
        |=> mem_addr_o == 16'($past(file_select_pointer0_o) + 16'h1)
        && file_select_pointer0_o == mem_addr_o) else $error("preincrement wrong");
    postdec_wrap_a: assert property (p0_w && pointer_update_code_i == imr_pkg::IMR_MM_POSTDEC
        |=> mem_addr_o == $past(file_select_pointer0_o)
        && file_select_pointer0_o == 16'($past(file_select_pointer0_o) - 16'h1))
        else $error("postdecrement wrong");
    rel_keep_a: assert property (rel_w |=> $stable(file_select_pointer0_o))
        else $error("relative store moved pointer");
    idle_pc_a: assert property (idle_w |-> done_o ##1 pc_o == 13'($past(pc_o) + 13'h1))
        else $error("idle wrong");
    ret_wait_a: assert property (ret_w |-> !done_o ##1 done_o)
        else $error("return length wrong");
    ret_pop_a: assert property (ret_w |=> global_interrupt_enable_o
        && stack_depth_o == 4'($past(stack_depth_o) - 4'h1)) else $error("return pop wrong");
    soft_reset_a: assert property (sr_w |=> soft_reset_o && !reset_instruction_flag_o)
        else $error("soft reset wrong");
    // Main scenarios reached
    cover property (ret_w);
    cover property (sr_w);
    cover property (rel_w);
endmodule // imr_props

// ---- sim/tb_top.sv ----
/* Directed bench for imr_core.
   Assumes imr_pkg compiled first; stimulus changes at falling edges. */
`timescale 1ns/10ps
module tb_top;
    logic sys_clk_i = 1'b0, resetn_i = 1'b0, start_i = 1'b0, ptr_sel_i = 1'b0;
    logic call_i = 1'b0, int_disable_i = 1'b0, reset_flag_set_i = 1'b0, d0;
    imr_pkg::imr_op_t op_i = imr_pkg::IMR_OP_NONE;
    logic [1:0] pointer_update_code_i = 2'h0;
    logic [5:0] offset_i = 6'h00;
    logic [7:0] accumulator_i = 8'h00;
    logic [12:0] call_target_i = 13'h0ABC;
    logic done_o, mem_we_o, global_interrupt_enable_o, reset_instruction_flag_o, soft_reset_o;
    logic [15:0] mem_addr_o, file_select_pointer0_o, file_select_pointer1_o;
    logic [7:0] mem_wdata_o, interrupt_control_register_o;
    logic [12:0] pc_o;
    logic [3:0] stack_depth_o;
    int failures = 0, n_compared = 0;
    imr_core dut_u (.*);
    // Clock at 20 MHz
    always #25 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////
    task automatic complete_run;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One instruction; returns in the cycle after the take
    task automatic run(input imr_pkg::imr_op_t o, input logic s, input logic [1:0] c,
        input logic [5:0] k);
        @(negedge sys_clk_i);
        op_i = o;
        ptr_sel_i = s;
        pointer_update_code_i = c;
        offset_i = k;
        accumulator_i = accumulator_i + 8'h11;
        start_i = 1'b1;
        #1 d0 = done_o;
        @(negedge sys_clk_i);
        start_i = 1'b0;
    endtask
    task automatic st(input imr_pkg::imr_op_t o, input logic s, input logic [1:0] c,
        input logic [5:0] k, input logic [15:0] ea, input logic [15:0] ep);
        run(o, s, c, k);
        cmp({14'h0, d0, mem_we_o}, 16'h3);
        cmp(mem_addr_o, ea);
        cmp({8'h0, mem_wdata_o}, {8'h0, accumulator_i});
        cmp(s ? file_select_pointer1_o : file_select_pointer0_o, ep);
    endtask
    ////////////////////////////////////////
    // Stop a hung run
    initial begin
        repeat (2000) @(posedge sys_clk_i);
        failures++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        resetn_i = 1'b1;
        st(imr_pkg::IMR_OP_STORE_IND, 1'b0, 2'h3, 6'h00, 16'h0000, 16'hFFFF);
        st(imr_pkg::IMR_OP_STORE_IND, 1'b0, 2'h0, 6'h00, 16'h0000, 16'h0000);
        st(imr_pkg::IMR_OP_STORE_IND, 1'b1, 2'h1, 6'h00, 16'hFFFF, 16'hFFFF);
        st(imr_pkg::IMR_OP_STORE_IND, 1'b1, 2'h2, 6'h00, 16'hFFFF, 16'h0000);
        st(imr_pkg::IMR_OP_STORE_REL, 1'b0, 2'h0, 6'h20, 16'hFFE0, 16'h0000);
        st(imr_pkg::IMR_OP_STORE_REL, 1'b1, 2'h0, 6'h1F, 16'h001F, 16'h0000);
        run(imr_pkg::IMR_OP_IDLE, 1'b0, 2'h0, 6'h00);
        cmp({15'h0, d0}, 16'h1);
        cmp({3'h0, pc_o}, 16'h0007);
        // Push one stack entry; the disable stays up into the return, which must win
        @(negedge sys_clk_i);
        {call_i, int_disable_i} = 2'h3;
        @(negedge sys_clk_i);
        call_i = 1'b0;
        cmp({12'h0, stack_depth_o}, 16'h1);
        cmp({3'h0, pc_o}, 16'h0ABC);
        cmp({8'h0, interrupt_control_register_o}, 16'h0);
        run(imr_pkg::IMR_OP_INT_RETURN, 1'b0, 2'h0, 6'h00);
        int_disable_i = 1'b0;
        cmp({14'h0, d0, done_o}, 16'h1);
        cmp({3'h0, pc_o}, 16'h0008);
        cmp({12'h0, stack_depth_o}, 16'h0);
        cmp({7'h0, global_interrupt_enable_o, interrupt_control_register_o}, 16'h180);
        // A lone disable pulse clears the enable again
        @(negedge sys_clk_i);
        int_disable_i = 1'b1;
        @(negedge sys_clk_i);
        int_disable_i = 1'b0;
        cmp({7'h0, global_interrupt_enable_o, interrupt_control_register_o}, 16'h000);
        run(imr_pkg::IMR_OP_SOFT_RESET, 1'b0, 2'h0, 6'h00);
        cmp({13'h0, d0, soft_reset_o, reset_instruction_flag_o}, 16'h6);
        // Flag set again afterwards; the reset pulse has dropped by then
        @(negedge sys_clk_i);
        reset_flag_set_i = 1'b1;
        @(negedge sys_clk_i);
        reset_flag_set_i = 1'b0;
        cmp({14'h0, soft_reset_o, reset_instruction_flag_o}, 16'h1);
        complete_run();
    end
endmodule // tb_top
bind imr_core imr_props chk_u (.*);
